// ### gtsm_pkg.sv
package gtsm_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_SMCTRL = 8'h08;
  localparam logic [7:0] OFF_DIEN = 8'h0c;
  localparam logic [7:0] OFF_STS = 8'h10;
  localparam logic [7:0] OFF_CEG = 8'h14;
  localparam logic [7:0] OFF_CCM1 = 8'h18;
  localparam logic [7:0] OFF_CCM2 = 8'h1c;
  localparam logic [7:0] OFF_CCEN = 8'h20;
  localparam logic [7:0] OFF_CNT = 8'h24;
  localparam logic [7:0] OFF_PSC = 8'h28;
  localparam logic [7:0] OFF_ARR = 8'h2c;
  localparam logic [7:0] OFF_CC1 = 8'h34;
  localparam logic [7:0] OFF_CC2 = 8'h38;
  localparam logic [7:0] OFF_CC3 = 8'h3c;
  localparam logic [7:0] OFF_CC4 = 8'h40;
  localparam logic [7:0] OFF_DCTRL = 8'h48;
  localparam logic [7:0] OFF_DMADDR = 8'h4c;
  localparam logic [7:0] OFF_OPT = 8'h50;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_RUN = 0;
  localparam int B_UDIS = 1;
  localparam int B_URS = 2;
  localparam int B_SPM = 3;
  localparam int B_DIR = 4;
  localparam int B_ARPE = 7;
  localparam int B_UIF = 0;
  localparam int B_CCF = 1;
  localparam int B_TIF = 6;
  localparam int B_UDE = 8;
  localparam int B_CCDE = 9;
  localparam int B_TDE = 14;
  // ----------------------------------------
  // Mode encodings
  // ----------------------------------------
  localparam logic [2:0] SM_ENC1 = 3'h1;
  localparam logic [2:0] SM_ENC2 = 3'h2;
  localparam logic [2:0] SM_ENC3 = 3'h3;
  localparam logic [2:0] SM_RESET = 3'h4;
  localparam logic [2:0] SM_GATED = 3'h5;
  localparam logic [2:0] SM_TRIG = 3'h6;
  localparam logic [2:0] TS_CH1ED = 3'h4;
  localparam logic [2:0] TS_CH1F = 3'h5;
  localparam logic [2:0] TS_CH2F = 3'h6;
  localparam logic [2:0] TS_ETR = 3'h7;
  localparam logic [2:0] OC_ACT = 3'h1;
  localparam logic [2:0] OC_INACT = 3'h2;
  localparam logic [2:0] OC_TOG = 3'h3;
  localparam logic [2:0] OC_FINACT = 3'h4;
  localparam logic [2:0] OC_FACT = 3'h5;
  localparam logic [2:0] OC_PWM1 = 3'h6;
  localparam logic [2:0] OC_PWM2 = 3'h7;
  localparam logic [1:0] SEL_OUT = 2'h0;
  localparam logic [1:0] SEL_DIRECT = 2'h1;
  localparam logic [1:0] SEL_PAIR = 2'h2;
  localparam logic [1:0] SEL_TRG = 2'h3;
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] ctrl1, ctrl2, smctrl, dien, sts, ccm1, ccm2, ccen;
    logic [15:0] cnt, psc, arr, dctrl, dmaddr, opt, psc_sh, arr_sh, pcnt;
    logic [3:0][15:0] ccr;
    logic [4:0][2:0] sy;
    logic [4:0] lvl;
    logic [3:0][3:0] fcnt;
    logic [3:0] ti, ti_d, oref, clr, out;
    logic trg_d;
    logic [5:0] dma;
    logic rdy;
    logic [31:0] rdata;
  } gtsm_state_t;
endpackage : gtsm_pkg

// ### gtsm_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - PWM input measurement uses only channels 1 and 2 and both capture registers.
// - Channel 1 input feeds two captures; the paired one takes opposite polarity.
// - Single-pulse mode emits one pulse, then stops the counter at update.
// - Update ending a single pulse clears the run bit; output follows the wrapped count.
// - Single pulse delay and width follow compare and reload, swapped counting down.
// - Output channel modes 100/101 force reference inactive/active, ignoring compare.
// - Forced outputs still raise compare flags and requests as usual.
// - Encoder counts on channel 1, channel 2, or both edges per mode select.
// - Encoder inputs pass polarity and input filters before edge detection.
// - Encoder mode makes direction read-only, recomputed on every input transition.
// - Both-input counting direction follows the quadrature table of edges and levels.
// - Follower mode select: 100 reset, 101 gated, 110 trigger.
// - Reset mode: trigger rising edge reinitialises counter, prescaler, issues update.
// - Gated mode counts only while trigger high; low stops without reset.
// - Trigger mode starts counter on rising trigger, never stops it.
// - Flags exist for update, trigger and capture/compare events.
// - Selected events raise DMA requests, each with its own enable bit.
// - With clear enabled, high external trigger holds reference low until update.
module gtsm_timer
  import gtsm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  input wire logic [3:0] ch_in,
  input wire logic etr_in,
  output logic [3:0] ch_out,
  output logic [5:0] dma_req
);

  gtsm_state_t r, nxt;
  logic [4:0] pins;
  logic wr, run, enc, ev1, ev2, down, step, ovf, sreset, ug, upd, selected_trigger_input, trg_rise;
  logic hit, cap, s, sp, p, e1, e2;
  logic [2:0] sms;
  logic [3:0] tp;
  logic [7:0] cb;
  logic [15:0] gen;

  assign pins = {etr_in, ch_in};

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [7:0] cfg(input int k);
    cfg = (k < 2) ? r.ccm1[(k % 2) * 8 +: 8] : r.ccm2[(k % 2) * 8 +: 8];
  endfunction : cfg

  function automatic logic [15:0] rdval(input logic [7:0] a);
    unique case (a)
      OFF_CTRL1: rdval = r.ctrl1;
      OFF_CTRL2: rdval = r.ctrl2;
      OFF_SMCTRL: rdval = r.smctrl;
      OFF_DIEN: rdval = r.dien;
      OFF_STS: rdval = r.sts;
      OFF_CCM1: rdval = r.ccm1;
      OFF_CCM2: rdval = r.ccm2;
      OFF_CCEN: rdval = r.ccen;
      OFF_CNT: rdval = r.cnt;
      OFF_PSC: rdval = r.psc;
      OFF_ARR: rdval = r.arr;
      OFF_CC1: rdval = r.ccr[0];
      OFF_CC2: rdval = r.ccr[1];
      OFF_CC3: rdval = r.ccr[2];
      OFF_CC4: rdval = r.ccr[3];
      OFF_DCTRL: rdval = r.dctrl;
      OFF_DMADDR: rdval = r.dmaddr;
      OFF_OPT: rdval = r.opt;
      default: rdval = 16'h0000;
    endcase
  endfunction : rdval

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt = r;
    wr = psel & penable & r.rdy & pwrite;
    gen = 16'h0000;
    sms = r.smctrl[2:0];
    enc = (sms == SM_ENC1) | (sms == SM_ENC2) | (sms == SM_ENC3);
    run = 1'b0;
    ev1 = 1'b0;
    ev2 = 1'b0;
    step = 1'b0;
    ovf = 1'b0;
    hit = 1'b0;
    cap = 1'b0;
    s = 1'b0;
    sp = 1'b0;
    p = 1'b0;
    cb = 8'h00;
    down = r.ctrl1[B_DIR];
    // Pin synchronisers: level counts once stages two and three agree
    for (int k = 0; k < 5; k++) begin
      nxt.sy[k] = {r.sy[k][1:0], pins[k]};
      if (r.sy[k][1] == r.sy[k][2]) begin
        nxt.lvl[k] = r.sy[k][2];
      end
    end
    // input filters ahead of edge logic
    for (int k = 0; k < 4; k++) begin
      cb = cfg(k);
      if (r.lvl[k] == r.ti[k]) begin
        nxt.fcnt[k] = 4'h0;
      end else if (r.fcnt[k] >= cb[7:4]) begin
        nxt.ti[k] = r.lvl[k];
        nxt.fcnt[k] = 4'h0;
      end else begin
        nxt.fcnt[k] = r.fcnt[k] + 4'h1;
      end
      tp[k] = r.ti[k] ^ r.ccen[4 * k + 1];
    end
    nxt.ti_d = r.ti;
    // Trigger source select
    unique case (r.smctrl[6:4])
      TS_CH1ED: selected_trigger_input = r.ti[0] ^ r.ti_d[0];
      TS_CH1F: selected_trigger_input = tp[0];
      TS_CH2F: selected_trigger_input = tp[1];
      TS_ETR: selected_trigger_input = r.lvl[4];
      default: selected_trigger_input = 1'b0;
    endcase
    nxt.trg_d = selected_trigger_input;
    trg_rise = selected_trigger_input & ~r.trg_d;
    // APB access
    nxt.rdy = psel & ~penable;
    nxt.rdata = 32'h0000_0000;
    if (psel & ~penable & ~pwrite) begin
      nxt.rdata = {16'h0000, rdval(paddr)};
    end
    if (wr) begin
      unique case (paddr)
        // direction bit kept in encoder mode
        OFF_CTRL1: nxt.ctrl1 = enc ? {pwdata[15:5], r.ctrl1[B_DIR], pwdata[3:0]}
                                   : pwdata[15:0];
        OFF_CTRL2: nxt.ctrl2 = pwdata[15:0];
        OFF_SMCTRL: nxt.smctrl = pwdata[15:0];
        OFF_DIEN: nxt.dien = pwdata[15:0];
        OFF_STS: nxt.sts = r.sts & pwdata[15:0];
        OFF_CEG: gen = pwdata[15:0];
        OFF_CCM1: nxt.ccm1 = pwdata[15:0];
        OFF_CCM2: nxt.ccm2 = pwdata[15:0];
        OFF_CCEN: nxt.ccen = pwdata[15:0];
        OFF_PSC: nxt.psc = pwdata[15:0];
        OFF_ARR: nxt.arr = pwdata[15:0];
        OFF_CC1: nxt.ccr[0] = pwdata[15:0];
        OFF_CC2: nxt.ccr[1] = pwdata[15:0];
        OFF_CC3: nxt.ccr[2] = pwdata[15:0];
        OFF_CC4: nxt.ccr[3] = pwdata[15:0];
        OFF_DCTRL: nxt.dctrl = pwdata[15:0];
        OFF_DMADDR: nxt.dmaddr = pwdata[15:0];
        OFF_OPT: nxt.opt = pwdata[15:0];
        default: ;
      endcase
    end
    e1 = r.ti[0] != r.ti_d[0];
    e2 = r.ti[1] != r.ti_d[1];
    ev1 = enc & (sms != SM_ENC2) & e1;
    ev2 = enc & (sms != SM_ENC1) & e2;
    // gated mode runs only while trigger high
    run = r.ctrl1[B_RUN] & ((sms != SM_GATED) | selected_trigger_input);
    if (enc) begin
      if (e1) begin
        down = (tp[0] == tp[1]);
      end else if (e2) begin
        down = (tp[1] != tp[0]);
      end
      nxt.ctrl1[B_DIR] = down;
      step = r.ctrl1[B_RUN] & (ev1 | ev2);
    end else if (run) begin
      if (r.pcnt >= r.psc_sh) begin
        nxt.pcnt = 16'h0000;
        step = 1'b1;
      end else begin
        nxt.pcnt = r.pcnt + 16'h0001;
      end
    end
    if (step) begin
      if (!down) begin
        ovf = (r.cnt >= r.arr_sh);
        nxt.cnt = ovf ? 16'h0000 : r.cnt + 16'h0001;
      end else begin
        ovf = (r.cnt == 16'h0000);
        nxt.cnt = ovf ? r.arr_sh : r.cnt - 16'h0001;
      end
    end
    // follower mode decode; reset mode reinitialises
    sreset = (sms == SM_RESET) & trg_rise;
    ug = gen[B_UIF] | sreset;
    if (ug) begin
      nxt.pcnt = 16'h0000;
      nxt.cnt = down ? r.arr_sh : 16'h0000;
    end
    if (wr && paddr == OFF_CNT) begin
      nxt.cnt = pwdata[15:0];
    end
    upd = (ovf | ug) & ~r.ctrl1[B_UDIS];
    if (upd) begin
      nxt.psc_sh = r.psc;
      nxt.arr_sh = r.arr;
    end
    if (!r.ctrl1[B_ARPE]) begin
      nxt.arr_sh = nxt.arr;
    end
    // update and trigger flags, set wins over clear
    if (upd & (~r.ctrl1[B_URS] | ovf)) begin
      nxt.sts[B_UIF] = 1'b1;
    end
    if (((sms == SM_RESET || sms == SM_TRIG) && trg_rise) || gen[B_TIF] ||
        (sms == SM_GATED && selected_trigger_input != r.trg_d)) begin
      nxt.sts[B_TIF] = 1'b1;
    end
    // single pulse stops counting at its update
    if (ovf & r.ctrl1[B_SPM]) begin
      nxt.ctrl1[B_RUN] = 1'b0;
    end
    // trigger mode only starts the counter
    if (sms == SM_TRIG && trg_rise) begin
      nxt.ctrl1[B_RUN] = 1'b1;
    end
    // Channels
    for (int k = 0; k < 4; k++) begin
      cb = cfg(k);
      if (cb[1:0] == SEL_OUT) begin
        hit = (step | ug) & (nxt.cnt == r.ccr[k]);
        // PWM compare gives delay and width
        case (cb[6:4])
          OC_ACT: if (hit) nxt.oref[k] = 1'b1;
          OC_INACT: if (hit) nxt.oref[k] = 1'b0;
          OC_TOG: if (hit) nxt.oref[k] = ~r.oref[k];
          OC_FINACT: nxt.oref[k] = 1'b0;
          OC_FACT: nxt.oref[k] = 1'b1;
          OC_PWM1: nxt.oref[k] = (nxt.cnt < r.ccr[k]);
          OC_PWM2: nxt.oref[k] = (nxt.cnt >= r.ccr[k]);
          default: ;
        endcase
        // compare flag raised in every output mode
        if (hit) begin
          nxt.sts[B_CCF + k] = 1'b1;
        end
        if (upd) begin
          nxt.clr[k] = 1'b0;
        end
        if (cb[7] & r.lvl[4]) begin
          nxt.clr[k] = 1'b1;
        end
        if (cb[7] & (r.lvl[4] | r.clr[k])) begin
          nxt.oref[k] = 1'b0;
        end
      end else begin
        p = r.ccen[4 * k + 1];
        unique case (cb[1:0])
          SEL_DIRECT: begin
            s = r.ti[k];
            sp = r.ti_d[k];
          end
          // paired input only on channels 1 and 2
          // paired path takes the opposite polarity
          SEL_PAIR: begin
            s = (k < 2) & r.ti[k ^ 1];
            sp = (k < 2) & r.ti_d[k ^ 1];
            p = ~r.ccen[4 * (k ^ 1) + 1];
          end
          default: begin
            s = selected_trigger_input;
            sp = r.trg_d;
          end
        endcase
        cap = r.ccen[4 * k] & (s ^ p) & ~(sp ^ p);
        if (cap) begin
          nxt.ccr[k] = r.cnt;
          nxt.sts[B_CCF + k] = 1'b1;
        end
      end
      if (gen[B_CCF + k]) begin
        nxt.sts[B_CCF + k] = 1'b1;
      end
      nxt.out[k] = r.ccen[4 * k] & (nxt.oref[k] ^ r.ccen[4 * k + 1]);
    end
    nxt.dma[0] = nxt.sts[B_UIF] & r.dien[B_UDE];
    for (int k = 0; k < 4; k++) begin
      nxt.dma[k + 1] = nxt.sts[B_CCF + k] & r.dien[B_CCDE + k];
    end
    nxt.dma[5] = nxt.sts[B_TIF] & r.dien[B_TDE];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign prdata = r.rdata;
  assign pready = r.rdy;
  assign ch_out = r.out;
  assign dma_req = r.dma;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_force_inactive: assert property (
    (r.ccm1[1:0] == SEL_OUT && r.ccm1[6:4] == OC_FINACT) |=> !r.oref[0])
    else $error("forced inactive reference not low");
  a_force_flag: assert property (
    (r.ccm1[1:0] == SEL_OUT && r.ccm1[6:4] == OC_FACT && step &&
     nxt.cnt == r.ccr[0]) |=> r.sts[B_CCF])
    else $error("forced output lost compare flag");
  a_spm_halt: assert property (
    (ovf && r.ctrl1[B_SPM] && !(sms == SM_TRIG && trg_rise)) |=> !r.ctrl1[B_RUN])
    else $error("single pulse did not halt");
  a_gate_hold: assert property (
    (sms == SM_GATED && !selected_trigger_input && !ug && !wr) |=> $stable(r.cnt))
    else $error("gated counter moved while trigger low");
  a_reset_trig: assert property (
    (sms == SM_RESET && trg_rise && !r.ctrl1[B_DIR] && !wr) |=>
    (r.cnt == 16'h0000 && r.pcnt == 16'h0000))
    else $error("reset mode did not reinitialise");
  a_trig_start: assert property (
    (sms == SM_TRIG && trg_rise) |=> r.ctrl1[B_RUN] ##1 r.ctrl1[B_RUN] || $past(ovf))
    else $error("trigger mode did not start counter");
  a_enc_dir: assert property (
    (sms == SM_ENC3 && ev1 && tp[0] && tp[1]) |=> r.ctrl1[B_DIR])
    else $error("encoder direction wrong");
  a_clear_low: assert property (
    (r.ccm1[1:0] == SEL_OUT && r.ccm1[7] && r.lvl[4]) |=> !r.oref[0] ##1 !r.oref[0])
    else $error("reference not held low by external clear");
  a_unmapped_zero: assert property (
    (psel && !penable && !pwrite && paddr == 8'h30) |=> (pready && prdata == 32'h0))
    else $error("unmapped read not zero");

  a_enc_dir_any: assert property (
    (enc && !e1 && e2 && tp[0] == tp[1]) |=> !r.ctrl1[B_DIR])
    else $error("encoder direction not recomputed");

  a_pair_capture: assert property (
    (r.ccm1[9:8] == SEL_PAIR && r.ccen[4] && !r.ccen[1] && r.ti_d[0] && !r.ti[0]) |=>
    (r.ccr[1] == $past(r.cnt)))
    else $error("paired capture missed falling edge");

  a_trig_dma: assert property (
    (r.dien[B_TDE] && r.sts[B_TIF] && !wr) |=> dma_req[5])
    else $error("trigger request missing");

  a_clear_off: assert property (
    (r.ccm1[1:0] == SEL_OUT && r.ccm1[6:4] == OC_FACT && !r.ccm1[7]) |=> r.oref[0])
    else $error("reference touched with clear disabled");

endmodule : gtsm_timer
`default_nettype wire

// ### gtsm_quad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Incremental encoder source
// ----------------------------------------
module gtsm_quad_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic step_req,
  input wire logic step_back,
  input wire logic [7:0] hold,
  output logic [1:0] quad,
  output logic busy
);
  logic [1:0] phase_r;
  logic [7:0] wait_r;
  // Gray pair, channel 1 leads going forward
  assign quad = {phase_r[1], phase_r[1] ^ phase_r[0]};
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_r <= 2'h0;
      wait_r <= 8'h00;
      busy <= 1'b0;
    end else if (busy) begin
      if (wait_r == 8'h00) begin
        busy <= 1'b0;
      end else begin
        wait_r <= wait_r - 8'h01;
      end
    end else if (step_req) begin
      phase_r <= step_back ? phase_r - 2'h1 : phase_r + 2'h1;
      wait_r <= hold;
      busy <= 1'b1;
    end
  end
endmodule : gtsm_quad_model
`default_nettype wire

// ### gtsm_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gtsm_timer_tb_top
  import gtsm_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv, v1;
  logic etr = 1'b0, pa = 1'b0, sel_pwm = 1'b0, q_req = 1'b0, q_back = 1'b0, q_busy;
  logic [3:0] ch_out, ch_in;
  logic [5:0] dma_req;
  logic [1:0] quad;
  int num_errors = 0, tests_run = 0, cyc = 0, d, w;

  always #5 clk = ~clk;
  assign ch_in = {2'b00, sel_pwm ? {~pa, pa} : quad};

  gtsm_timer gtsm_timer_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .ch_in(ch_in), .etr_in(etr), .ch_out(ch_out), .dma_req(dma_req));
  gtsm_quad_model gtsm_quad_model_i (.clk(clk), .nrst(nrst), .step_req(q_req),
    .step_back(q_back), .hold(8'h0c), .quad(quad), .busy(q_busy));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic ck(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : ck

  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [15:0] dat);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= {16'h0000, dat};
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    ck("pready wait", n, 32'h1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] dat);
    apb(1'b1, a, dat);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 16'h0000);
  endtask : rd

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask : waitc

  task automatic steps(input int n, input logic back);
    int k;
    repeat (n) begin
      q_req <= 1'b1;
      q_back <= back;
      @(posedge clk);
      q_req <= 1'b0;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (q_busy === 1'b1 && k < 40);
    end
  endtask : steps

  task automatic out1(input string nm, input logic e);
    @(posedge clk);
    ck(nm, {31'h0, ch_out[0]}, {31'h0, e});
  endtask : out1

  function automatic logic [15:0] ocb(input logic [2:0] m, input logic c);
    return {8'h00, c, m, 2'b00, SEL_OUT};
  endfunction : ocb

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      $display("[ERR] cycle limit exp %0d seen %0d", 39999, cyc);
      end_of_test();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    wr(8'h30, 16'h1234);
    rd(8'h30);
    ck("unmapped", rv, 32'h0);
    wr(OFF_ARR, 16'h00ff);
    rd(OFF_ARR);
    ck("reload", rv, 32'h00ff);
    wr(OFF_CEG, 16'h0040);
    rd(OFF_CEG);
    ck("event gen", rv, 32'h0);
    rd(OFF_STS);
    ck("trig flag", {31'h0, rv[B_TIF]}, 32'h1);
    $display("test registers done");
    wr(OFF_ARR, 16'h0009);
    wr(OFF_CC1, 16'h0004);
    wr(OFF_CCEN, 16'h0001);
    wr(OFF_DIEN, 16'h0200);
    wr(OFF_STS, 16'h0000);
    wr(OFF_CCM1, ocb(OC_FINACT, 1'b0));
    wr(OFF_CTRL1, 16'h0001);
    waitc(30);
    out1("forced low", 1'b0);
    rd(OFF_STS);
    ck("cmp flag", {31'h0, rv[B_CCF]}, 32'h1);
    ck("cmp dma", {31'h0, dma_req[1]}, 32'h1);
    wr(OFF_CCM1, ocb(OC_FACT, 1'b0));
    waitc(3);
    out1("forced high", 1'b1);
    $display("test forced done");
    wr(OFF_CTRL1, 16'h0000);
    wr(OFF_ARR, 16'h0008);
    wr(OFF_CC1, 16'h0003);
    // Up: delay compare, width reload minus compare; down: swapped
    for (int dn = 0; dn < 2; dn++) begin
      wr(OFF_CNT, dn ? 16'h0008 : 16'h0000);
      wr(OFF_CCM1, ocb(dn ? OC_PWM1 : OC_PWM2, 1'b0));
      wr(OFF_CTRL1, dn ? 16'h0019 : 16'h0009);
      d = -1;
      w = 0;
      for (int i = 0; i < 40; i++) begin
        @(posedge clk);
        if (ch_out[0] === 1'b1) begin
          if (w == 0) d = i;
          w++;
        end
      end
      ck("pulse delay", 32'(dn ? (d >= 4 && d <= 7) : (d >= 2 && d <= 6)), 32'h1);
      ck("pulse width", 32'(dn ? (w == 3 || w == 4) : (w == 5 || w == 6)), 32'h1);
      rd(OFF_CTRL1);
      ck("run cleared", {31'h0, rv[B_RUN]}, 32'h0);
      rd(OFF_CNT);
      v1 = rv;
      waitc(8);
      rd(OFF_CNT);
      ck("stopped", rv, v1);
    end
    $display("test single pulse done");
    wr(OFF_CCEN, 16'h0000);
    wr(OFF_CCM1, 16'h0101);
    wr(OFF_ARR, 16'hffff);
    wr(OFF_CTRL1, 16'h0001);
    for (int m = 1; m <= 3; m++) begin
      wr(OFF_SMCTRL, 16'(m));
      wr(OFF_CNT, 16'h0000);
      steps(4, 1'b0);
      rd(OFF_CNT);
      ck("enc fwd", rv, (m == 3) ? 32'h4 : 32'h2);
      steps(4, 1'b1);
      rd(OFF_CNT);
      ck("enc back", rv, 32'h0);
    end
    rd(OFF_CTRL1);
    ck("enc dir", {31'h0, rv[B_DIR]}, 32'h1);
    wr(OFF_CTRL1, 16'h0001);
    rd(OFF_CTRL1);
    ck("dir read only", {31'h0, rv[B_DIR]}, 32'h1);
    wr(OFF_CTRL1, 16'h0000);
    wr(OFF_CCEN, 16'h0002);
    wr(OFF_CNT, 16'h0000);
    wr(OFF_CTRL1, 16'h0001);
    steps(4, 1'b0);
    rd(OFF_CNT);
    ck("enc inverted", rv, 32'h0000fffc);
    wr(OFF_CTRL1, 16'h0000);
    wr(OFF_CCEN, 16'h0000);
    $display("test encoder done");
    wr(OFF_SMCTRL, {9'h000, TS_ETR, 1'b0, SM_GATED});
    wr(OFF_CNT, 16'h0000);
    wr(OFF_CTRL1, 16'h0001);
    waitc(10);
    rd(OFF_CNT);
    ck("gate closed", rv, 32'h0);
    etr <= 1'b1;
    waitc(20);
    etr <= 1'b0;
    waitc(10);
    rd(OFF_CNT);
    v1 = rv;
    waitc(10);
    rd(OFF_CNT);
    ck("gate hold", rv, v1);
    ck("gate count", 32'(v1 >= 17 && v1 <= 23), 32'h1);
    wr(OFF_CTRL1, 16'h0000);
    wr(OFF_STS, 16'h0000);
    wr(OFF_DIEN, 16'h4000);
    wr(OFF_SMCTRL, {9'h000, TS_ETR, 1'b0, SM_TRIG});
    etr <= 1'b1;
    waitc(10);
    etr <= 1'b0;
    waitc(10);
    rd(OFF_CTRL1);
    ck("trig start", {31'h0, rv[B_RUN]}, 32'h1);
    rd(OFF_CNT);
    v1 = rv;
    rd(OFF_CNT);
    ck("trig no stop", 32'(rv > v1), 32'h1);
    rd(OFF_STS);
    ck("trig event", {31'h0, rv[B_TIF]}, 32'h1);
    ck("trig dma", {31'h0, dma_req[5]}, 32'h1);
    wr(OFF_STS, 16'h0000);
    wr(OFF_DIEN, 16'h0100);
    wr(OFF_SMCTRL, {9'h000, TS_ETR, 1'b0, SM_RESET});
    rd(OFF_CNT);
    v1 = rv;
    etr <= 1'b1;
    waitc(8);
    rd(OFF_CNT);
    ck("reset restart", 32'(rv < 32'd16 && v1 > 32'd30), 32'h1);
    rd(OFF_STS);
    ck("reset update", {31'h0, rv[B_UIF]}, 32'h1);
    ck("update dma", {31'h0, dma_req[0]}, 32'h1);
    wr(OFF_DIEN, 16'h0000);
    waitc(2);
    ck("dma off", {31'h0, dma_req[0]}, 32'h0);
    etr <= 1'b0;
    $display("test follower done");
    wr(OFF_SMCTRL, 16'h0000);
    wr(OFF_ARR, 16'h00c8);
    wr(OFF_CC1, 16'hffff);
    wr(OFF_CCM1, ocb(OC_PWM1, 1'b0));
    wr(OFF_CCEN, 16'h0001);
    wr(OFF_CTRL1, 16'h0001);
    etr <= 1'b1;
    waitc(8);
    out1("clear off", 1'b1);
    etr <= 1'b0;
    wr(OFF_CCM1, ocb(OC_PWM1, 1'b1));
    wr(OFF_CNT, 16'h0000);
    etr <= 1'b1;
    waitc(8);
    etr <= 1'b0;
    waitc(8);
    out1("clear held", 1'b0);
    waitc(200);
    out1("clear ends", 1'b1);
    $display("test ref clear done");
    wr(OFF_CTRL1, 16'h0000);
    wr(OFF_CCEN, 16'h0011);
    wr(OFF_CCM1, {6'h00, SEL_PAIR, 6'h00, SEL_DIRECT});
    wr(OFF_SMCTRL, {9'h000, TS_CH1F, 1'b0, SM_RESET});
    sel_pwm <= 1'b1;
    wr(OFF_CTRL1, 16'h0001);
    pa <= 1'b1;
    waitc(30);
    pa <= 1'b0;
    waitc(50);
    pa <= 1'b1;
    waitc(10);
    rd(OFF_CC1);
    ck("period", 32'(rv >= 32'd77 && rv <= 32'd83), 32'h1);
    rd(OFF_CC2);
    ck("duty", 32'(rv >= 32'd27 && rv <= 32'd33), 32'h1);
    $display("test pwm input done");
    end_of_test();
  end
endmodule : gtsm_timer_tb_top
`default_nettype wire
